// ### design/eew_pkg.sv
// Shared constants, states and carriers of the two-wire EEPROM slave write path.
// Assumes one system clock; all bus pins are sampled by that clock.
package eew_pkg;
    // Array geometry: 256 pages of 32 bytes, 13-bit linear address
    localparam int PAGES = 256;
    localparam int PAGE_BYTES = 32;
    localparam int ADDR_W = 13;
    localparam int OFS_W = 5;
    localparam int MEM_BYTES = PAGES * PAGE_BYTES;

    // Bit counts within one byte frame
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] TX_LAST_BIT = 4'h7;

    // Which byte of a write transfer is being received
    localparam logic [1:0] IDX_DEV = 2'h0;
    localparam logic [1:0] IDX_HI = 2'h1;
    localparam logic [1:0] IDX_LO = 2'h2;
    localparam logic [1:0] IDX_DATA = 2'h3;

    // Field positions in the address byte
    localparam int TYPE_MSB = 7;
    localparam int TYPE_LSB = 4;
    localparam int HW_MSB = 3;
    localparam int HW_LSB = 1;
    localparam int DIR_BIT = 0;
    localparam int HI_ADDR_BITS = 5;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_RACK = 3'b100,
        ST_RNEXT = 3'b101,
        ST_PROG = 3'b110
    } eew_state_t;

    // Package variant: how many hardware address pins exist
    typedef enum logic [1:0] {
        PKG_FULL = 2'b00,
        PKG_SIX = 2'b01,
        PKG_FOUR = 2'b10
    } eew_variant_t;

    // Pins sampled together through the synchroniser
    typedef struct packed {
        logic scl;
        logic sda;
        logic a_hi;
        logic a_mid;
        logic a_lo;
        logic wp;
    } eew_pins_t;
endpackage

// ### design/eew_slave.sv
// Two-wire EEPROM slave: addressing, byte/page write, programming, read-out.
// Assumes SCL and SDA arrive asynchronously from a master much slower than clock;
// SDA is open drain, the bench resolves the wire from sda_oe.
//
// Overview of operation
// - After reset sit in standby until Start.
// - Stop without programming returns to standby.
// - Programming end returns to standby, ready again.
// - Address mismatch: no acknowledge, back to standby.
// - Master not-acknowledge on read data: release, standby.
// - Release SDA within nine recovery clocks.
// - Array is 256 pages of 32 bytes.
// - Upper four address bits hold type identifier.
// - Bits 3..1 compared with address pins.
// - Small packages force low address bits zero.
// - Bit 0 chooses read or write.
// - Full match: acknowledge on ninth clock.
// - Word address is 13 bits, two bytes.
// - Acknowledge word-address bytes and data bytes.
// - Stop after data starts programming; bus ignored.
// - Page write takes 1..32 bytes in one row.
// - Up to 31 extra data bytes, each acknowledged.
// - Only low five address bits advance.
// - Past page end wraps to same page start.
// - Busy: address byte unacknowledged; afterwards acknowledged.
// - Start and Stop are SDA edges, SCL high.
// - Sample on SCL rise, change on fall, MSB first.
// - Ninth clock carries acknowledge or not-acknowledge.
// - Write protect at Stop: skip programming.
`timescale 1ns/1ps

module eew_slave #(
    parameter eew_pkg::eew_variant_t VARIANT = eew_pkg::PKG_FULL,
    parameter int PROG_CYCLES = 1000,
    parameter logic [3:0] DEV_TYPE_ID = 4'h6 // Arbitrary value
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic hw_addr_pin_high,
    input wire logic hw_addr_pin_mid,
    input wire logic hw_addr_pin_low,
    input wire logic write_protect,
    output logic busy
);
    localparam int CNT_W = $clog2(PROG_CYCLES + 1);

    eew_pkg::eew_pins_t pins_raw;
    eew_pkg::eew_pins_t sync1_r;
    eew_pkg::eew_pins_t sync2_r;
    eew_pkg::eew_pins_t prev_r;
    eew_pkg::eew_state_t st_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [1:0] idx_r;
    logic rw_r;
    logic have_data_r;
    logic [eew_pkg::ADDR_W-1:0] addr_r;
    logic [eew_pkg::PAGE_BYTES-1:0] mask_r;
    logic [CNT_W-1:0] prog_cnt_r;
    logic [7:0] mem [eew_pkg::MEM_BYTES];
    logic [7:0] page_buf [eew_pkg::PAGE_BYTES];

    // Pins through two flops; the second stage and its delayed copy feed edge logic
    assign pins_raw = '{scl: scl_in, sda: sda_in, a_hi: hw_addr_pin_high,
                        a_mid: hw_addr_pin_mid, a_lo: hw_addr_pin_low, wp: write_protect};

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r <= 6'h3F;
            sync2_r <= 6'h3F;
            prev_r <= 6'h3F;
        end else begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // Bus events, all seen in the same clock as the second synchroniser flop takes the new level
    wire scl_rise = sync2_r.scl & ~prev_r.scl;
    wire scl_fall = ~sync2_r.scl & prev_r.scl;
    wire start_det = sync2_r.scl & prev_r.scl & prev_r.sda & ~sync2_r.sda;
    wire stop_det = sync2_r.scl & prev_r.scl & ~prev_r.sda & sync2_r.sda;
    wire in_prog = (st_r == eew_pkg::ST_PROG);
    wire byte_done = (st_r == eew_pkg::ST_RX) && (bit_cnt_r == eew_pkg::BYTE_BITS) && scl_fall;

    // Expected hardware bits; missing pins in small packages read as zero
    wire exp_hi = (VARIANT == eew_pkg::PKG_FOUR) ? 1'b0 : sync2_r.a_hi;
    wire exp_mid = (VARIANT == eew_pkg::PKG_FULL) ? sync2_r.a_mid : 1'b0;
    wire exp_lo = (VARIANT == eew_pkg::PKG_FULL) ? sync2_r.a_lo : 1'b0;
    wire type_ok = shift_r[eew_pkg::TYPE_MSB:eew_pkg::TYPE_LSB] == DEV_TYPE_ID;
    wire hw_ok = shift_r[eew_pkg::HW_MSB:eew_pkg::HW_LSB] == {exp_hi, exp_mid, exp_lo};
    wire addr_match = type_ok & hw_ok;
    wire dev_byte = byte_done && (idx_r == eew_pkg::IDX_DEV);
    wire data_byte = byte_done && (idx_r == eew_pkg::IDX_DATA);
    wire prog_end = in_prog && (prog_cnt_r == CNT_W'(PROG_CYCLES - 1));
    wire [eew_pkg::OFS_W-1:0] ofs = addr_r[eew_pkg::OFS_W-1:0];
    wire [eew_pkg::OFS_W-1:0] ofs_inc = ofs + 5'h01;
    wire [7:0] rd_byte = mem[addr_r];

    // Open drain: only ever pulls low; ack in the ninth clock, zeros while sending
    assign sda_out = 1'b0;
    assign sda_oe = (st_r == eew_pkg::ST_ACK) || ((st_r == eew_pkg::ST_TX) && !tx_r[7]);
    assign busy = in_prog;

    // Protocol engine; Start and Stop take priority over clock edges
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= eew_pkg::ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'hFF;
            idx_r <= eew_pkg::IDX_DEV;
            rw_r <= 1'b0;
            have_data_r <= 1'b0;
            addr_r <= '0;
            mask_r <= '0;
            prog_cnt_r <= '0;
        end else if (in_prog) begin
            // Bus is deaf while programming, so polling bytes go unanswered
            prog_cnt_r <= prog_cnt_r + CNT_W'(1);
            if (prog_end) begin
                st_r <= eew_pkg::ST_IDLE;
                mask_r <= '0;
                have_data_r <= 1'b0;
            end
        end else if (start_det) begin
            // Repeated Start also discards an unfinished write
            st_r <= eew_pkg::ST_RX;
            bit_cnt_r <= 4'h0;
            idx_r <= eew_pkg::IDX_DEV;
            have_data_r <= 1'b0;
            mask_r <= '0;
        end else if (stop_det) begin
            // Only whole data bytes are buffered, so a partial byte is dropped
            if (have_data_r && !sync2_r.wp) begin
                st_r <= eew_pkg::ST_PROG;
                prog_cnt_r <= '0;
            end else begin
                st_r <= eew_pkg::ST_IDLE;
                mask_r <= '0;
                have_data_r <= 1'b0;
            end
        end else begin
            case (st_r)
                eew_pkg::ST_RX: begin
                    if (scl_rise && bit_cnt_r != eew_pkg::BYTE_BITS) begin
                        shift_r <= {shift_r[6:0], sync2_r.sda};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt_r <= 4'h0;
                        st_r <= eew_pkg::ST_ACK;
                        case (idx_r)
                            eew_pkg::IDX_DEV: begin
                                rw_r <= shift_r[eew_pkg::DIR_BIT];
                                idx_r <= eew_pkg::IDX_HI;
                                if (!addr_match) begin
                                    st_r <= eew_pkg::ST_IDLE;
                                end
                            end
                            eew_pkg::IDX_HI: begin
                                addr_r[eew_pkg::ADDR_W-1:8] <= shift_r[eew_pkg::HI_ADDR_BITS-1:0];
                                idx_r <= eew_pkg::IDX_LO;
                            end
                            eew_pkg::IDX_LO: begin
                                addr_r[7:0] <= shift_r;
                                idx_r <= eew_pkg::IDX_DATA;
                            end
                            default: begin
                                // Row bits stay, offset wraps inside the page
                                addr_r[eew_pkg::OFS_W-1:0] <= ofs_inc;
                                mask_r[ofs] <= 1'b1;
                                have_data_r <= 1'b1;
                            end
                        endcase
                    end
                end
                eew_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        if (rw_r && idx_r == eew_pkg::IDX_HI) begin
                            st_r <= eew_pkg::ST_TX;
                            tx_r <= rd_byte;
                            addr_r <= addr_r + 13'h0001;
                        end else begin
                            st_r <= eew_pkg::ST_RX;
                        end
                    end
                end
                eew_pkg::ST_TX: begin
                    // Data released at the eighth falling edge for the master's answer
                    if (scl_fall) begin
                        if (bit_cnt_r == eew_pkg::TX_LAST_BIT) begin
                            st_r <= eew_pkg::ST_RACK;
                            bit_cnt_r <= 4'h0;
                        end else begin
                            tx_r <= {tx_r[6:0], 1'b1};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                    end
                end
                eew_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        st_r <= sync2_r.sda ? eew_pkg::ST_IDLE : eew_pkg::ST_RNEXT;
                    end
                end
                eew_pkg::ST_RNEXT: begin
                    if (scl_fall) begin
                        st_r <= eew_pkg::ST_TX;
                        tx_r <= rd_byte;
                        addr_r <= addr_r + 13'h0001;
                    end
                end
                default: begin
                    st_r <= eew_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Page buffer and array; no reset on storage, unwritten cells read unknown
    always_ff @(posedge clock) begin
        if (data_byte && !in_prog && !start_det && !stop_det) begin
            page_buf[ofs] <= shift_r;
        end
        if (prog_end) begin
            for (int i = 0; i < eew_pkg::PAGE_BYTES; i++) begin
                if (mask_r[i]) begin
                    mem[{addr_r[eew_pkg::ADDR_W-1:eew_pkg::OFS_W], 5'(i)}] <= page_buf[i];
                end
            end
        end
    end

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_dev_mismatch;
        dev_byte && !addr_match && !start_det && !stop_det;
    endsequence
    sequence s_dev_match;
        dev_byte && addr_match && !start_det && !stop_det;
    endsequence

    property p_stop_idle;
        stop_det && !in_prog && !have_data_r |=> st_r == eew_pkg::ST_IDLE && !sda_oe;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop did not return to standby");

    property p_prog_done;
        prog_end |=> st_r == eew_pkg::ST_IDLE && !busy && mask_r == '0;
    endproperty
    a_prog_done: assert property (p_prog_done) else $error("programming end not standby");

    property p_mismatch;
        s_dev_mismatch |=> st_r == eew_pkg::ST_IDLE ##1 !sda_oe;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("mismatched address answered");

    property p_match_ack;
        s_dev_match |=> sda_oe && st_r == eew_pkg::ST_ACK;
    endproperty
    a_match_ack: assert property (p_match_ack) else $error("matched address not acked");

    property p_prog_deaf;
        in_prog |-> !sda_oe;
    endproperty
    a_prog_deaf: assert property (p_prog_deaf) else $error("drove SDA while programming");

    property p_row_fixed;
        data_byte && !start_det && !stop_det && !in_prog
            |=> addr_r[12:5] == $past(addr_r[12:5])
                && addr_r[4:0] == 5'($past(addr_r[4:0]) + 5'h01);
    endproperty
    a_row_fixed: assert property (p_row_fixed) else $error("page row changed on data");

    property p_wrap;
        data_byte && !start_det && !stop_det && !in_prog && ofs == 5'h1F |=> ofs == 5'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("offset did not wrap in page");

    property p_read_nack;
        st_r == eew_pkg::ST_RACK && scl_rise && sync2_r.sda && !start_det && !stop_det
            |=> st_r == eew_pkg::ST_IDLE && !sda_oe;
    endproperty
    a_read_nack: assert property (p_read_nack) else $error("read nack not standby");

    property p_wp_skip;
        stop_det && !in_prog && sync2_r.wp |=> !busy [*2];
    endproperty
    a_wp_skip: assert property (p_wp_skip) else $error("protected write programmed");

    property p_start;
        start_det && !in_prog |=> st_r == eew_pkg::ST_RX && bit_cnt_r == 4'h0 && !have_data_r;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

endmodule

// ### test/eew_master.sv
// Two-wire bus master model: drives SCL and an open-drain enable for SDA.
// Assumes a pull-up on SDA; the bench resolves the wire and feeds it back.
`timescale 1ns/1ps

module eew_master (
    output logic scl,
    output logic sda_oe,
    input wire logic sda
);
    localparam realtime Q = 31.25; // Quarter of the 125 ns bus period

    // Bus clock stands still high between frames
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end

    // One clock; SDA moves only while SCL is low, taken mid-high
    task automatic bit_io(input logic b, output logic s);
        #Q sda_oe = ~b;
        #Q scl = 1'b1;
        #Q s = sda;
        #Q scl = 1'b0;
    endtask

    // Release first, so a repeated Start also sees SDA high
    task automatic start();
        #Q sda_oe = 1'b0;
        #Q scl = 1'b1;
        #Q sda_oe = 1'b1;
        #Q scl = 1'b0;
    endtask

    task automatic stop();
        #Q sda_oe = 1'b1;
        #Q scl = 1'b1;
        #Q sda_oe = 1'b0;
        #(2 * Q);
    endtask

    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    // Ninth clock carries our ack or nack
    task automatic rbyte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(nack, s);
    endtask
endmodule

// ### test/tb.sv
// Self-checking bench for the EEPROM slave write path on the two-wire bus.
// Assumes the master model eew_master and a pull-up on the SDA wire.
`timescale 1ns/1ps

module tb;
    localparam int PROG = 400; // Long enough for one poll to land while busy
    localparam logic [3:0] TYPE_ID = 4'h6; // Arbitrary value
    logic clock;
    logic reset_n;
    logic [2:0] pins;
    logic wp;
    logic scl;
    logic m_oe;
    logic sda_out;
    logic sda_oe;
    logic busy;
    logic ack;
    logic six_oe;
    logic four_oe;
    logic [7:0] db;
    logic lvl;
    logic [7:0] rd [0:31];
    int k;
    int miscompares;
    int cmp_count;
    // Open-drain wire: high unless some party pulls
    wire sda_w = (sda_oe ? sda_out : 1'b1) & ~m_oe & ~six_oe & ~four_oe;

    eew_slave #(.VARIANT(eew_pkg::PKG_FULL), .PROG_CYCLES(PROG), .DEV_TYPE_ID(TYPE_ID))
        eew_slave_inst (.clock(clock), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe), .hw_addr_pin_high(pins[2]),
        .hw_addr_pin_mid(pins[1]), .hw_addr_pin_low(pins[0]), .write_protect(wp),
        .busy(busy));
    // Small-package variants share the bus; their addresses never clash with the main part
    eew_slave #(.VARIANT(eew_pkg::PKG_SIX), .PROG_CYCLES(PROG), .DEV_TYPE_ID(TYPE_ID))
        eew_slave_six_inst (.clock(clock), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_w),
        .sda_out(), .sda_oe(six_oe), .hw_addr_pin_high(pins[2]),
        .hw_addr_pin_mid(pins[1]), .hw_addr_pin_low(pins[0]), .write_protect(wp),
        .busy());
    eew_slave #(.VARIANT(eew_pkg::PKG_FOUR), .PROG_CYCLES(PROG), .DEV_TYPE_ID(TYPE_ID))
        eew_slave_four_inst (.clock(clock), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_w),
        .sda_out(), .sda_oe(four_oe), .hw_addr_pin_high(pins[2]),
        .hw_addr_pin_mid(pins[1]), .hw_addr_pin_low(pins[0]), .write_protect(wp),
        .busy());
    eew_master eew_master_inst (.scl(scl), .sda_oe(m_oe), .sda(sda_w));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    function automatic logic [7:0] dw(input logic r);
        return {TYPE_ID, pins, r};
    endfunction

    task automatic dev(input logic [7:0] b, input logic exp);
        eew_master_inst.start();
        eew_master_inst.wbyte(b, ack);
        check("device ack", {7'h00, exp}, {7'h00, ack});
    endtask

    task automatic waddr(input logic [12:0] a);
        dev(dw(1'b0), 1'b1);
        eew_master_inst.wbyte({3'h0, a[12:8]}, ack);
        check("hi ack", 8'h01, {7'h00, ack});
        eew_master_inst.wbyte(a[7:0], ack);
        check("lo ack", 8'h01, {7'h00, ack});
    endtask

    task automatic wr(input logic [12:0] a, input int n, input logic [7:0] base);
        waddr(a);
        for (int i = 0; i < n; i++) begin
            eew_master_inst.wbyte(base + 8'(i), ack);
            check("data ack", 8'h01, {7'h00, ack});
        end
        eew_master_inst.stop();
        repeat (3) @(negedge clock);
    endtask

    // Random read: dummy write of the address, repeated Start, read
    task automatic rdn(input logic [12:0] a, input int n);
        waddr(a);
        dev(dw(1'b1), 1'b1);
        for (int i = 0; i < n; i++) begin
            eew_master_inst.rbyte(i == n - 1, rd[i]);
        end
        eew_master_inst.stop();
        check("sda released", 8'h00, {7'h00, sda_oe});
    endtask

    // Bounded wait for the end of programming
    task automatic wait_prog(output int n);
        n = 0;
        while (busy !== 1'b0 && n < PROG + 50) begin
            @(negedge clock);
            n++;
        end
        check("busy end", 8'h00, {7'h00, busy});
    endtask

    // Tests need about 16,000 clocks; allow roughly three times that before giving up
    initial begin
        #400000;
        miscompares++;
        $display("watchdog expired");
        give_verdict();
    end

    initial begin
        reset_n = 1'b0;
        pins = 3'h5;
        wp = 1'b0;
        miscompares = 0;
        cmp_count = 0;
        repeat (16) @(negedge clock);
        reset_n = 1'b1;
        repeat (4) @(negedge clock);
        check("idle", 8'h00, {6'h00, busy, sda_oe});
        // Byte write, then polling during and after programming
        wr(13'h0123, 1, 8'hA5);
        check("busy", 8'h01, {7'h00, busy});
        dev(dw(1'b0), 1'b0);
        eew_master_inst.stop();
        wait_prog(k);
        dev(dw(1'b0), 1'b1);
        eew_master_inst.stop();
        rdn(13'h0123, 1);
        check("byte", 8'hA5, rd[0]);
        $display("test byte_write done");
        // Full page of 32 bytes from offset 30: offset wraps to the page start
        wr(13'h1F1E, 32, 8'h40);
        wait_prog(k);
        check("prog length", 8'h01, {7'h00, k >= PROG - 12 && k <= PROG});
        rdn(13'h1F00, 32);
        for (int i = 0; i < 32; i++) begin
            check("page", (i == 30) ? 8'h40 : (i == 31) ? 8'h41 : 8'h42 + 8'(i), rd[i]);
        end
        $display("test page_wrap done");
        // Protected write is acknowledged but not programmed
        @(negedge clock);
        wp = 1'b1;
        wr(13'h0123, 1, 8'h5A);
        check("wp busy", 8'h00, {7'h00, busy});
        wp = 1'b0;
        rdn(13'h0123, 1);
        check("wp byte", 8'hA5, rd[0]);
        $display("test protect done");
        // Repeated Start after data discards it
        waddr(13'h0040);
        eew_master_inst.wbyte(8'h77, ack);
        eew_master_inst.start();
        eew_master_inst.stop();
        repeat (3) @(negedge clock);
        check("abort busy", 8'h00, {7'h00, busy});
        $display("test abort done");
        // Master loses count before the ninth clock; dummy clocks must free SDA
        db = dw(1'b0);
        eew_master_inst.start();
        for (int i = 7; i >= 0; i--) begin
            eew_master_inst.bit_io(db[i], lvl);
        end
        k = 0;
        lvl = 1'b0;
        while (lvl !== 1'b1 && k < 9) begin
            eew_master_inst.bit_io(1'b1, lvl);
            k++;
        end
        check("recovery clocks", 8'h02, 8'(k));
        eew_master_inst.start();
        eew_master_inst.stop();
        dev(dw(1'b0), 1'b1);
        eew_master_inst.stop();
        $display("test recovery done");
        // Wrong type nibble, then wrong hardware bits after the straps move
        dev({~TYPE_ID, pins, 1'b0}, 1'b0);
        eew_master_inst.stop();
        // Small packages ignore their missing pins and want zeros in those bits
        dev({TYPE_ID, pins[2], 2'h0, 1'b0}, 1'b1);
        eew_master_inst.stop();
        dev({TYPE_ID, 3'h0, 1'b0}, 1'b1);
        eew_master_inst.stop();
        @(negedge clock);
        pins = 3'h3;
        repeat (4) @(negedge clock);
        dev({TYPE_ID, 3'h5, 1'b0}, 1'b0);
        eew_master_inst.stop();
        dev(dw(1'b0), 1'b1);
        eew_master_inst.stop();
        $display("test addressing done");
        give_verdict();
    end
endmodule
